/* pkg/sdso_pkg.sv */
// Constants, types and carriers for the sense-data serial output port.
// Assumes a 20 MHz system clock and a bit clock supplied by an external audio host.
// Overview of operation
// - Decimate each modulator stream to one sample per frame.
// - Slot one carries the signed current sample.
// - Slot two carries the signed voltage sample.
// - Slot three: supply byte on top, low byte zero.
// - Port is clock slave; host drives both clocks.
// - Frame sync rising edge starts a TDM frame.
// - First MSB appears one bit clock after sync.
// - Every TDM slot spans 64 bit clocks.
// - Measure frame length; adapt to 4-16 slots.
// - All link timing comes from the bit clock.
// - Slot strap picks one of four slot groups.
// - Slot strap is read once at startup.
// - Output is high impedance in undriven slots.
// - Fourth slot of the group stays undriven.
// - Swapped clock wiring selects I2S or left-justified.
// - Host gives 64 bit clocks per word clock.
// - Voltage while word clock low, current while high.
// - Supply byte appended below voltage: 24-bit word.
// - Strap selects I2S, left-justified, supply, low power.
// - Standard formats run from 16 to 48 kHz.
// - Low-power I2S: 32 or 64 bit clocks.
// - Bit clock loss powers down; return powers up.
// - No frame sync: converters off, no data.
// - Single-bit sync pulses mean TDM, not half duty.
package sdso_pkg;

  localparam int SAMPLE_W = 16;
  localparam int SUPPLY_W = 8;
  localparam int VSUP_W = 24;
  localparam int CNT_W = 11;

  localparam logic [10:0] MAX_FRAME_LEN = 11'h400;
  localparam logic [10:0] CNT_SAT = 11'h7ff;
  localparam logic [10:0] I2S_FRAME_LEN = 11'h040;
  localparam logic [10:0] LP_FRAME_LEN = 11'h020;
  localparam logic [10:0] ONE_BIT = 11'h001;
  localparam logic [2:0] TDM_OSR_LOG2 = 3'h7;
  localparam logic [2:0] I2S_OSR_LOG2 = 3'h6;
  localparam logic [2:0] LP_OSR_LOG2 = 3'h5;
  localparam logic [3:0] SAMPLE_MSB = 4'hf;
  localparam logic [3:0] SUPPLY_MSB = 4'h8;
  localparam logic [4:0] VSUP_MSB = 5'h17;
  localparam logic [5:0] WORD_END = 6'h10;
  localparam logic [5:0] SUPPLY_PAD_START = 6'h08;

  // Bit-count field positions inside a TDM frame: 64-bit slots, four slots per group.
  localparam int SLOT_LSB = 6;
  localparam int GROUP_LSB = 8;
  localparam int LEN_MOD_LSB = 7;
  localparam logic [1:0] CUR_SLOT = 2'h0;
  localparam logic [1:0] VOLT_SLOT = 2'h1;
  localparam logic [1:0] SUP_SLOT = 2'h2;
  localparam logic [1:0] IDLE_SLOT = 2'h3;

  localparam logic signed [20:0] SAT_POS = 21'sh07fff;
  localparam logic signed [20:0] SAT_NEG = -21'sh08000;
  localparam logic [11:0] SUP_SAT = 12'h0ff;

  localparam int SYS_PERIOD_NS = 50;
  localparam int CLK_LOSS_NS = 1000;
  localparam int CLK_LOSS_CYC = (CLK_LOSS_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // Five-level strap as reported by the pad level detector.
  typedef enum logic [2:0] {
    SDSO_TIE_HIGH,
    SDSO_OPEN,
    SDSO_TIE_LOW,
    SDSO_RES_HIGH,
    SDSO_RES_LOW
  } sdso_strap_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] current;
    logic [SAMPLE_W-1:0] voltage;
    logic [SUPPLY_W-1:0] supply;
  } sdso_sample_t;

  typedef struct packed {
    logic swapped;
    logic leftJust;
    logic supplyOn;
    logic lowPower;
    logic tdmOk;
    logic [1:0] group;
  } sdso_cfg_t;

endpackage

/* src/sdso_serial_out.sv */
// Sense-data serial transmitter: TDM slot output or I2S and left-justified output.
// Assumes linkClk is the host bit clock as routed by the pad ring for the wiring in use,
// and that the modulator bits change on linkClk.
`timescale 1ns/1ps
module sdso_serial_out #(
  parameter int LOSS_CYCLES = sdso_pkg::CLK_LOSS_CYC
) (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Straps.
  input wire sdso_pkg::sdso_strap_t slotStrap,
  input wire logic clkWiringSwapped,
  // Serial link.
  input wire logic linkClk,
  input wire logic bitclkOrWordclkBall,
  input wire logic frameOrBitclkBall,
  output logic senseSerialOut,
  output logic senseSerialOutOe,
  // Sense modulators.
  input wire logic currentModBit,
  input wire logic voltageModBit,
  input wire logic supplyModBit,
  output logic modStrobe,
  // Power control.
  output logic senseEnable,
  output logic lowPowerState
);

  localparam int LOSS_W = $clog2(LOSS_CYCLES + 1);

  // ---------------- System domain ----------------
  sdso_pkg::sdso_strap_t strapS1_r;
  sdso_pkg::sdso_strap_t strapS2_r;
  sdso_pkg::sdso_strap_t strapCode_r;
  logic swapS1_r;
  logic swapS2_r;
  logic swapped_r;
  logic [1:0] settle_r;
  logic strapDone_r;
  logic beatS1_r;
  logic beatS2_r;
  logic beatS3_r;
  logic beatEdge;
  logic [LOSS_W-1:0] lossCnt_r;
  logic bitClkLost_r;
  logic lostS1_r;
  logic lostS2_r;
  logic senseEnable_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strapS1_r <= sdso_pkg::SDSO_TIE_HIGH;
      strapS2_r <= sdso_pkg::SDSO_TIE_HIGH;
      swapS1_r <= 1'b0;
      swapS2_r <= 1'b0;
    end else begin
      strapS1_r <= slotStrap;
      strapS2_r <= strapS1_r;
      swapS1_r <= clkWiringSwapped;
      swapS2_r <= swapS1_r;
    end
  end

  // Straps are caught once, after the synchronisers have filled, and then held.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      settle_r <= 2'h0;
      strapDone_r <= 1'b0;
      strapCode_r <= sdso_pkg::SDSO_TIE_HIGH;
      swapped_r <= 1'b0;
    end else if (!strapDone_r) begin
      settle_r <= settle_r + 2'h1;
      if (settle_r == 2'h2) begin
        strapDone_r <= 1'b1;
        strapCode_r <= strapS2_r;
        swapped_r <= swapS2_r;
      end
    end
  end

  logic linkBeat_r;
  logic frameLost;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      beatS1_r <= 1'b0;
      beatS2_r <= 1'b0;
      beatS3_r <= 1'b0;
      lostS1_r <= 1'b1;
      lostS2_r <= 1'b1;
    end else begin
      beatS1_r <= linkBeat_r;
      beatS2_r <= beatS1_r;
      beatS3_r <= beatS2_r;
      lostS1_r <= frameLost;
      lostS2_r <= lostS1_r;
    end
  end

  assign beatEdge = beatS2_r ^ beatS3_r;

  // A quiet bit clock for the timeout drops the block into its lowest power state.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lossCnt_r <= '0;
      bitClkLost_r <= 1'b1;
    end else if (beatEdge) begin
      lossCnt_r <= '0;
      bitClkLost_r <= 1'b0;
    end else if (lossCnt_r == LOSS_W'(LOSS_CYCLES - 1)) begin
      bitClkLost_r <= 1'b1;
    end else begin
      lossCnt_r <= lossCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      senseEnable_r <= 1'b0;
    end else begin
      senseEnable_r <= strapDone_r && !bitClkLost_r && !lostS2_r;
    end
  end

  assign senseEnable = senseEnable_r;
  assign lowPowerState = bitClkLost_r;

  // ---------------- Link domain ----------------
  logic [1:0] linkRstPipe_r;
  logic linkRst;
  logic [1:0] doneS_r;
  logic cfgValid_r;
  sdso_pkg::sdso_cfg_t cfg_r;
  sdso_pkg::sdso_cfg_t cfgNxt;

  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      linkRstPipe_r <= 2'h3;
    end else begin
      linkRstPipe_r <= {linkRstPipe_r[0], 1'b0};
    end
  end

  assign linkRst = linkRstPipe_r[1];

  always_comb begin
    cfgNxt = '0;
    cfgNxt.swapped = swapped_r;
    unique case (strapCode_r)
      sdso_pkg::SDSO_TIE_HIGH: begin
        cfgNxt.tdmOk = 1'b1;
        cfgNxt.group = 2'h0;
      end
      sdso_pkg::SDSO_OPEN: begin
        cfgNxt.tdmOk = 1'b1;
        cfgNxt.group = 2'h1;
        cfgNxt.leftJust = 1'b1;
      end
      sdso_pkg::SDSO_TIE_LOW: begin
        cfgNxt.tdmOk = 1'b1;
        cfgNxt.group = 2'h2;
        cfgNxt.supplyOn = 1'b1;
      end
      sdso_pkg::SDSO_RES_HIGH: begin
        cfgNxt.tdmOk = 1'b1;
        cfgNxt.group = 2'h3;
        cfgNxt.leftJust = 1'b1;
        cfgNxt.supplyOn = 1'b1;
      end
      sdso_pkg::SDSO_RES_LOW: begin
        cfgNxt.lowPower = 1'b1;
      end
      default: begin
        cfgNxt.tdmOk = 1'b0;
      end
    endcase
  end

  // The strap word is stable once its done flag has crossed, so it is safe to take then.
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      doneS_r <= 2'h0;
      cfgValid_r <= 1'b0;
      cfg_r <= '0;
    end else begin
      doneS_r <= {doneS_r[0], strapDone_r};
      if (doneS_r[1] && !cfgValid_r) begin
        cfgValid_r <= 1'b1;
        cfg_r <= cfgNxt;
      end
    end
  end

  // Frame timing follows the incoming bit clock only.
  logic fsLevel;
  logic fsPrev_r;
  logic frameStart;
  logic [10:0] bitCnt_r;
  logic [10:0] frameLen_r;
  logic lenOk_r;
  logic lenOk;
  logic wideSeen_r;
  logic halfDuty_r;
  logic active;

  assign fsLevel = cfg_r.swapped ? bitclkOrWordclkBall : frameOrBitclkBall;
  assign frameStart = cfg_r.swapped ? (!fsLevel && fsPrev_r) : (fsLevel && !fsPrev_r);
  assign frameLost = bitCnt_r >= sdso_pkg::MAX_FRAME_LEN;

  always_comb begin
    if (cfg_r.swapped) begin
      lenOk = (bitCnt_r + sdso_pkg::ONE_BIT == sdso_pkg::I2S_FRAME_LEN) ||
              (cfg_r.lowPower && bitCnt_r + sdso_pkg::ONE_BIT == sdso_pkg::LP_FRAME_LEN);
    end else begin
      lenOk = (bitCnt_r[sdso_pkg::GROUP_LSB-1:0] == '1) && !frameLost;
    end
  end

  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      linkBeat_r <= 1'b0;
      fsPrev_r <= 1'b0;
      bitCnt_r <= sdso_pkg::CNT_SAT;
      frameLen_r <= '0;
      lenOk_r <= 1'b0;
    end else begin
      linkBeat_r <= !linkBeat_r;
      fsPrev_r <= fsLevel;
      if (frameStart) begin
        bitCnt_r <= '0;
        frameLen_r <= bitCnt_r + sdso_pkg::ONE_BIT;
        lenOk_r <= lenOk;
      end else if (bitCnt_r != sdso_pkg::CNT_SAT) begin
        bitCnt_r <= bitCnt_r + sdso_pkg::ONE_BIT;
      end
    end
  end

  // A sync held high for two bit clocks marks a half-duty clock, which this port does not serve.
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      wideSeen_r <= 1'b0;
      halfDuty_r <= 1'b0;
    end else if (frameStart) begin
      wideSeen_r <= 1'b0;
      halfDuty_r <= wideSeen_r;
    end else if (fsLevel && fsPrev_r) begin
      wideSeen_r <= 1'b1;
    end
  end

  assign active = cfgValid_r && lenOk_r && !frameLost &&
                  (cfg_r.swapped || (cfg_r.tdmOk && !halfDuty_r));

  // Decimation: the modulator is clocked at 128 fs from a divided bit clock in TDM, and at the bit clock itself in I2S and left-justified.
  logic [3:0] modDiv;
  logic [3:0] modCnt_r;
  logic [2:0] osrLog2;
  logic signed [8:0] accCur_r;
  logic signed [8:0] accVolt_r;
  logic [8:0] onesSup_r;
  sdso_pkg::sdso_sample_t samples_r;
  logic signed [8:0] curStep;
  logic signed [8:0] voltStep;
  logic [8:0] supStep;

  assign modDiv = cfg_r.swapped ? 4'h1 : frameLen_r[sdso_pkg::LEN_MOD_LSB+3:sdso_pkg::LEN_MOD_LSB];
  assign osrLog2 = !cfg_r.swapped ? sdso_pkg::TDM_OSR_LOG2 :
                   (frameLen_r == sdso_pkg::LP_FRAME_LEN) ? sdso_pkg::LP_OSR_LOG2 : sdso_pkg::I2S_OSR_LOG2;
  assign modStrobe = active && (modCnt_r == 4'h0);
  // The modulator bit of the frame-start cycle still belongs to the closing frame.
  assign curStep = !modStrobe ? 9'sh000 : currentModBit ? 9'sh001 : -9'sh001;
  assign voltStep = !modStrobe ? 9'sh000 : voltageModBit ? 9'sh001 : -9'sh001;
  assign supStep = {8'h00, modStrobe && supplyModBit};

  function automatic logic [15:0] scaleSigned(input logic signed [8:0] acc, input logic [2:0] lg);
    logic signed [20:0] wide;
    wide = 21'(acc) <<< (sdso_pkg::SAMPLE_MSB - {1'b0, lg});
    if (wide > sdso_pkg::SAT_POS) begin
      scaleSigned = sdso_pkg::SAT_POS[15:0];
    end else if (wide < sdso_pkg::SAT_NEG) begin
      scaleSigned = sdso_pkg::SAT_NEG[15:0];
    end else begin
      scaleSigned = wide[15:0];
    end
  endfunction

  function automatic logic [7:0] scaleSupply(input logic [8:0] ones, input logic [2:0] lg);
    logic [11:0] wide;
    wide = 12'({3'h0, ones} << (sdso_pkg::SUPPLY_MSB - {1'b0, lg}));
    scaleSupply = (wide > sdso_pkg::SUP_SAT) ? sdso_pkg::SUP_SAT[7:0] : wide[7:0];
  endfunction

  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      modCnt_r <= '0;
    end else if (frameStart || modCnt_r + 4'h1 >= modDiv) begin
      modCnt_r <= '0;
    end else begin
      modCnt_r <= modCnt_r + 4'h1;
    end
  end

  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      accCur_r <= '0;
      accVolt_r <= '0;
      onesSup_r <= '0;
      samples_r <= '0;
    end else if (frameStart) begin
      if (active) begin
        samples_r.current <= scaleSigned(accCur_r + curStep, osrLog2);
        samples_r.voltage <= scaleSigned(accVolt_r + voltStep, osrLog2);
        samples_r.supply <= scaleSupply(onesSup_r + supStep, osrLog2);
      end
      accCur_r <= '0;
      accVolt_r <= '0;
      onesSup_r <= '0;
    end else if (modStrobe) begin
      accCur_r <= accCur_r + curStep;
      accVolt_r <= accVolt_r + voltStep;
      onesSup_r <= onesSup_r + supStep;
    end
  end

  // Output word selection for the bit that the host samples on the next rising edge.
  logic [1:0] tdmGroup;
  logic [1:0] tdmSlot;
  logic [5:0] tdmBit;
  logic [15:0] tdmWord;
  logic [10:0] posNext;
  logic [10:0] pos;
  logic [10:0] halfLen;
  logic upperHalf;
  logic [10:0] halfPos;
  logic [23:0] i2sWord;
  logic driveOe;
  logic driveBit;

  assign tdmGroup = bitCnt_r[sdso_pkg::GROUP_LSB+1:sdso_pkg::GROUP_LSB];
  assign tdmSlot = bitCnt_r[sdso_pkg::GROUP_LSB-1:sdso_pkg::SLOT_LSB];
  assign tdmBit = bitCnt_r[sdso_pkg::SLOT_LSB-1:0];
  assign halfLen = frameLen_r >> 1;
  assign posNext = bitCnt_r + sdso_pkg::ONE_BIT;

  always_comb begin
    tdmWord = '0;
    unique case (tdmSlot)
      sdso_pkg::CUR_SLOT: tdmWord = samples_r.current;
      sdso_pkg::VOLT_SLOT: tdmWord = samples_r.voltage;
      sdso_pkg::SUP_SLOT: tdmWord = {samples_r.supply, 8'h00};
      sdso_pkg::IDLE_SLOT: tdmWord = '0;
    endcase
  end

  always_comb begin
    if (cfg_r.leftJust) begin
      pos = (posNext >= frameLen_r) ? posNext - frameLen_r : posNext;
    end else begin
      pos = bitCnt_r;
    end
    upperHalf = pos >= halfLen;
    halfPos = upperHalf ? pos - halfLen : pos;
    if (upperHalf) begin
      i2sWord = {samples_r.current, 8'h00};
    end else begin
      i2sWord = {samples_r.voltage, cfg_r.supplyOn ? samples_r.supply : 8'h00};
    end
  end

  always_comb begin
    driveOe = 1'b0;
    driveBit = 1'b0;
    if (active && cfg_r.swapped) begin
      driveOe = 1'b1;
      if (halfPos < 11'(sdso_pkg::VSUP_W)) begin
        driveBit = i2sWord[sdso_pkg::VSUP_MSB - halfPos[4:0]];
      end
    end else if (active) begin
      driveOe = (tdmGroup == cfg_r.group) && (tdmSlot != sdso_pkg::IDLE_SLOT);
      if (tdmBit < sdso_pkg::WORD_END) begin
        driveBit = tdmWord[sdso_pkg::SAMPLE_MSB - tdmBit[3:0]];
      end
    end
  end

  // Data changes on the falling edge so the host can take it on the rising edge.
  always_ff @(negedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      senseSerialOut <= 1'b0;
      senseSerialOutOe <= 1'b0;
    end else begin
      senseSerialOut <= driveOe && driveBit;
      senseSerialOutOe <= driveOe;
    end
  end

  // ---------------- Checks ----------------
  logic tdmRun;
  assign tdmRun = cfgValid_r && !cfg_r.swapped;

  a_frame_restart: assert property (@(posedge linkClk) disable iff (linkRst)
    frameStart |=> (bitCnt_r == '0) ##1 (bitCnt_r == sdso_pkg::ONE_BIT))
    else $error("bit counter did not restart on frame sync");

  a_first_msb: assert property (@(posedge linkClk) disable iff (linkRst)
    tdmRun && senseSerialOutOe && bitCnt_r[sdso_pkg::GROUP_LSB-1:0] == '0
    |-> senseSerialOut == samples_r.current[sdso_pkg::SAMPLE_W-1])
    else $error("slot one MSB wrong");

  a_fourth_idle: assert property (@(posedge linkClk) disable iff (linkRst)
    tdmRun && tdmSlot == sdso_pkg::IDLE_SLOT |-> !senseSerialOutOe)
    else $error("fourth slot driven");

  a_group_only: assert property (@(posedge linkClk) disable iff (linkRst)
    tdmRun && senseSerialOutOe |-> tdmGroup == cfg_r.group)
    else $error("drive outside own slot group");

  a_tail_low: assert property (@(posedge linkClk) disable iff (linkRst)
    tdmRun && senseSerialOutOe && tdmBit >= sdso_pkg::WORD_END |-> !senseSerialOut)
    else $error("slot tail not low");

  a_supply_pad: assert property (@(posedge linkClk) disable iff (linkRst)
    tdmRun && senseSerialOutOe && tdmSlot == sdso_pkg::SUP_SLOT &&
    tdmBit >= sdso_pkg::SUPPLY_PAD_START && tdmBit < sdso_pkg::WORD_END |-> !senseSerialOut)
    else $error("supply low byte not zero");

  a_nosync_quiet: assert property (@(posedge linkClk) disable iff (linkRst)
    frameLost [*2] |-> !senseSerialOutOe)
    else $error("data driven without frame sync");

  a_wide_sync_off: assert property (@(posedge linkClk) disable iff (linkRst)
    tdmRun && halfDuty_r |=> !senseSerialOutOe)
    else $error("half duty sync treated as TDM");

  a_clk_return: assert property (@(posedge clk_sys) disable iff (reset)
    beatEdge |=> !bitClkLost_r ##1 !lowPowerState)
    else $error("bit clock return did not wake block");

  a_strap_hold: assert property (@(posedge clk_sys) disable iff (reset)
    strapDone_r |=> $stable(strapCode_r) && $stable(swapped_r))
    else $error("strap changed after startup");

  c_tdm_drive: cover property (@(posedge linkClk) disable iff (linkRst)
    tdmRun && senseSerialOutOe && tdmSlot == sdso_pkg::SUP_SLOT);

  c_i2s_drive: cover property (@(posedge linkClk) disable iff (linkRst)
    cfg_r.swapped && senseSerialOutOe && upperHalf);

  c_clk_loss: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(bitClkLost_r));

endmodule

/* verif/sdso_host_model.sv */
// Host model: makes the bit clock and the frame or word clock, samples the serial data.
// Assumes a pull-down on the data line; the bench reads the captured bits by frame position.
`timescale 1ns/1ps
module sdso_host_model (
  // Controls from the bench.
  input wire logic run,
  input wire logic swapped,
  input wire logic [1:0] syncMode,
  input wire logic [10:0] frameLen,
  // Serial data from the device.
  input wire logic serialOut,
  input wire logic serialOutOe,
  // Clocks to the device.
  output logic bitClk,
  output logic bitclkOrWordclkBall,
  output logic frameOrBitclkBall,
  // Captured frame.
  output logic [1023:0] dataBuf,
  output logic [1023:0] oeBuf,
  output int frameCnt
);
  logic [10:0] txPos = 11'h000;
  logic [10:0] nxtPos;
  logic [9:0] rxPos = 10'h000;
  logic lvl = 1'b0;
  logic prevLvl = 1'b0;
  logic line;

  // The clock stops low when run drops, so a stopped clock looks lost.
  initial begin
    bitClk = 1'b0;
    frameCnt = 0;
    #37;
    forever begin
      #80;
      if (run || bitClk) bitClk = ~bitClk;
    end
  end

  assign nxtPos = (txPos >= frameLen - 11'h001) ? 11'h000 : txPos + 11'h001;
  assign frameOrBitclkBall = swapped ? bitClk : lvl;
  assign bitclkOrWordclkBall = swapped ? lvl : bitClk;
  assign line = serialOutOe ? serialOut : 1'b0;

  always @(negedge bitClk) begin
    txPos <= nxtPos;
    if (swapped) lvl <= nxtPos >= (frameLen >> 1);
    else if (syncMode == 2'h1) lvl <= 1'b0;
    else if (syncMode == 2'h2) lvl <= nxtPos < (frameLen >> 1);
    else lvl <= nxtPos == 11'h000;
  end

  always @(posedge bitClk) begin
    prevLvl <= lvl;
    dataBuf[rxPos] <= line;
    oeBuf[rxPos] <= serialOutOe;
    if (swapped ? (prevLvl && !lvl) : (lvl && !prevLvl)) begin
      rxPos <= 10'h000;
      frameCnt <= frameCnt + 1;
    end else if (rxPos != 10'h3ff) begin
      rxPos <= rxPos + 10'h001;
    end
  end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the sense-data serial port in TDM, I2S and left-justified wiring.
// Assumes the host model makes the 160 ns link clock and stands for the data pull-down.
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic swp;
    sdso_pkg::sdso_strap_t strap;
    logic [10:0] len;
    logic cur;
    logic volt;
    logic sup;
  } sdso_tb_row_t;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  sdso_pkg::sdso_strap_t slotStrap = sdso_pkg::SDSO_TIE_HIGH;
  logic clkWiringSwapped = 1'b0;
  logic curBit = 1'b0;
  logic voltBit = 1'b0;
  logic supBit = 1'b0;
  logic run = 1'b1;
  logic [1:0] syncMode = 2'h0;
  logic [10:0] frameLen = 11'h100;
  logic linkClk, wordBall, frameBall, serOut, serOe, senseEnable, lowPowerState;
  logic [1023:0] dataBuf, oeBuf;
  int frameCnt;
  int error_cnt = 0;
  int checks = 0;
  logic modStrobe;
  int strobeCnt = 0;
  sdso_tb_row_t rows[9];

  always #25 clk_sys = ~clk_sys;
  always @(posedge linkClk) strobeCnt <= strobeCnt + int'(modStrobe);

  sdso_host_model i_host (.run(run), .swapped(clkWiringSwapped), .syncMode(syncMode), .frameLen(frameLen),
    .serialOut(serOut), .serialOutOe(serOe), .bitClk(linkClk), .bitclkOrWordclkBall(wordBall),
    .frameOrBitclkBall(frameBall), .dataBuf(dataBuf), .oeBuf(oeBuf), .frameCnt(frameCnt));

  sdso_serial_out #(.LOSS_CYCLES(8)) i_dut (.clk_sys(clk_sys), .reset(reset), .slotStrap(slotStrap),
    .clkWiringSwapped(clkWiringSwapped), .linkClk(linkClk), .bitclkOrWordclkBall(wordBall),
    .frameOrBitclkBall(frameBall), .senseSerialOut(serOut), .senseSerialOutOe(serOe),
    .currentModBit(curBit), .voltageModBit(voltBit), .supplyModBit(supBit), .modStrobe(modStrobe),
    .senseEnable(senseEnable), .lowPowerState(lowPowerState));

  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Writes the low n bits of val MSB first from position base on.
  task automatic place(inout logic [1023:0] v, input int base, input logic [23:0] val, input int n);
    for (int i = 0; i < n; i++) v[base + i] = val[n - 1 - i];
  endtask

  task automatic frames(input int n);
    int f0;
    f0 = frameCnt;
    wait (frameCnt >= f0 + n);
    @(negedge clk_sys);
  endtask

  task automatic start(input sdso_tb_row_t r, input logic [1:0] mode);
    @(negedge clk_sys);
    reset = 1'b1;
    clkWiringSwapped = r.swp;
    slotStrap = r.strap;
    frameLen = r.len;
    curBit = r.cur;
    voltBit = r.volt;
    supBit = r.sup;
    syncMode = mode;
    // Long enough for two link clock edges inside reset.
    repeat (7) @(negedge clk_sys);
    reset = 1'b0;
    // Two spare frames cover a sync that lands while the link side is still leaving reset.
    frames(5);
  endtask

  task automatic check(input sdso_tb_row_t r);
    logic [1023:0] ed;
    logic [1023:0] eo;
    logic [1023:0] rot;
    logic [15:0] cur;
    logic [15:0] vlt;
    logic [7:0] sup;
    logic [63:0] m;
    int g;
    int s0;
    s0 = strobeCnt;
    frames(1);
    cmp(64'(strobeCnt - s0), r.swp ? 64'(r.len) : 64'h80);
    cur = r.cur ? 16'h7fff : 16'h8000;
    vlt = r.volt ? 16'h7fff : 16'h8000;
    sup = r.sup ? 8'hff : 8'h00;
    ed = '0;
    eo = '0;
    g = int'(r.strap);
    if (!r.swp) begin
      place(ed, g * 256, {8'h00, cur}, 16);
      place(ed, g * 256 + 64, {8'h00, vlt}, 16);
      place(ed, g * 256 + 128, {16'h0000, sup}, 8);
      eo[g * 256 +: 192] = '1;
    end else begin
      for (int i = 0; i < r.len; i++) eo[i] = 1'b1;
      if (r.len == 11'h020) place(ed, 0, {8'h00, vlt}, 16);
      else if (r.strap == sdso_pkg::SDSO_TIE_LOW || r.strap == sdso_pkg::SDSO_RES_HIGH) place(ed, 0, {vlt, sup}, 24);
      else place(ed, 0, {vlt, 8'h00}, 24);
      place(ed, r.len / 2, {8'h00, cur}, 16);
      // Left-justified data leads the I2S layout by one bit.
      if (r.strap == sdso_pkg::SDSO_OPEN || r.strap == sdso_pkg::SDSO_RES_HIGH) begin
        rot = ed;
        for (int i = 0; i < r.len; i++) ed[i] = rot[(i + 1) % r.len];
      end
    end
    m = (r.len == 11'h020) ? 64'h0000_0000_ffff_ffff : '1;
    for (int c = 0; c < (r.len + 63) / 64; c++) begin
      cmp(dataBuf[c * 64 +: 64] & m, ed[c * 64 +: 64] & m);
      cmp(oeBuf[c * 64 +: 64] & m, eo[c * 64 +: 64] & m);
    end
    cmp({63'h0, senseEnable}, 64'h1);
    cmp({63'h0, lowPowerState}, 64'h0);
  endtask

  initial begin
    rows = '{
      '{1'b0, sdso_pkg::SDSO_TIE_HIGH, 11'h100, 1'b1, 1'b0, 1'b1},
      '{1'b0, sdso_pkg::SDSO_OPEN, 11'h200, 1'b0, 1'b1, 1'b0},
      '{1'b0, sdso_pkg::SDSO_TIE_LOW, 11'h300, 1'b1, 1'b1, 1'b1},
      '{1'b0, sdso_pkg::SDSO_RES_HIGH, 11'h400, 1'b0, 1'b0, 1'b1},
      '{1'b1, sdso_pkg::SDSO_TIE_HIGH, 11'h040, 1'b1, 1'b0, 1'b1},
      '{1'b1, sdso_pkg::SDSO_OPEN, 11'h040, 1'b0, 1'b1, 1'b1},
      '{1'b1, sdso_pkg::SDSO_TIE_LOW, 11'h040, 1'b1, 1'b1, 1'b1},
      '{1'b1, sdso_pkg::SDSO_RES_HIGH, 11'h040, 1'b0, 1'b0, 1'b1},
      '{1'b1, sdso_pkg::SDSO_RES_LOW, 11'h020, 1'b1, 1'b0, 1'b0}
    };
    repeat (3) @(negedge clk_sys);
    cmp({61'h0, serOe, senseEnable, lowPowerState}, 64'h1);
    for (int k = 0; k < 9; k++) begin
      start(rows[k], 2'h0);
      check(rows[k]);
    end
    // A strap change while running must not move the slot group.
    start(rows[0], 2'h0);
    slotStrap = sdso_pkg::SDSO_OPEN;
    frames(2);
    check(rows[0]);
    run = 1'b0;
    repeat (40) @(negedge clk_sys);
    cmp({63'h0, lowPowerState}, 64'h1);
    run = 1'b1;
    repeat (40) @(negedge clk_sys);
    cmp({63'h0, lowPowerState}, 64'h0);
    syncMode = 2'h1;
    repeat (4200) @(negedge clk_sys);
    cmp({62'h0, senseEnable, serOe}, 64'h0);
    start(rows[0], 2'h2);
    for (int c = 0; c < 4; c++) cmp(oeBuf[c * 64 +: 64], 64'h0);
    stop_test;
  end

  initial begin
    #(90000 * 50);
    error_cnt++;
    stop_test;
  end
endmodule
